// ===== alsp_pkg.sv
/*
  Package for the light interrupt persistence and configuration block.
  It holds register offsets, field positions, reset values, timing and states.
  It assumes a 50 MHz system clock.
*/
package alsp_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int WAIT_STEP_NS = 2730000;
  localparam int WAIT_STEP_CYC = WAIT_STEP_NS / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] PERSIST_ADDR = 8'h0C;
  localparam logic [7:0] CFG_ADDR = 8'h0D;
  localparam logic [7:0] STATUS_ADDR = 8'h13;
  localparam logic [7:0] PERSIST_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int PERSIST_MSB = 3;
  localparam int CFG_RG_BIT = 2;
  localparam int CFG_LW_BIT = 1;
  localparam int STATUS_PEND_BIT = 4;

  // ------------------------------------------------------------
  // Field encodings
  // ------------------------------------------------------------
  localparam logic [3:0] PERSIST_EVERY = 4'h0;
  localparam logic [3:0] PERSIST_LINEAR_MAX = 4'h3;
  localparam logic [1:0] GAIN_8X = 2'h1;
  localparam logic [3:0] LWAIT_FACTOR = 4'hC;
  localparam logic [8:0] WAIT_SPAN = 9'h100;

  typedef enum logic [1:0] {
    ALSP_WT_IDLE = 2'b00,
    ALSP_WT_RUN = 2'b01,
    ALSP_WT_DONE = 2'b11
  } alsp_wait_e;

endpackage

// ===== alsp_wait_timer.sv
/*
  Wait timer: counts programmed wait cycles of one step each, optionally x12.
  Assumes a one-cycle start pulse and a steady wait count during the wait.
*/
`timescale 1ns/1ns
`default_nettype none
module alsp_wait_timer #(
  parameter int STEP_CYC = alsp_pkg::WAIT_STEP_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic wait_start,
  input wire logic [7:0] wait_cycle_count,
  input wire logic long_wait_multiplier,
  output logic wait_busy,
  output logic wait_done
);

  alsp_pkg::alsp_wait_e state, next_state;
  logic [17:0] step_cnt, next_step_cnt;
  logic [11:0] steps_left, next_steps_left;
  logic [11:0] span;

  // ------------------------------------------------------------
  // Step count from the programmed value
  // ------------------------------------------------------------
  // two's complement count
  always_comb begin
    span = {3'h0, alsp_pkg::WAIT_SPAN - {1'b0, wait_cycle_count}};
    if (long_wait_multiplier) begin
      span = 12'(span * alsp_pkg::LWAIT_FACTOR);
    end
  end

  always_comb begin
    next_state = state;
    next_step_cnt = step_cnt;
    next_steps_left = steps_left;
    case (state)
      alsp_pkg::ALSP_WT_IDLE: begin
        if (wait_start) begin
          next_state = alsp_pkg::ALSP_WT_RUN;
          next_steps_left = span;
          next_step_cnt = 18'(STEP_CYC - 1);
        end
      end
      alsp_pkg::ALSP_WT_RUN: begin
        if (step_cnt != 18'h0) begin
          next_step_cnt = step_cnt - 18'h1;
        end else if (steps_left == 12'h1) begin
          next_state = alsp_pkg::ALSP_WT_DONE;
        end else begin
          next_steps_left = steps_left - 12'h1;
          next_step_cnt = 18'(STEP_CYC - 1);
        end
      end
      alsp_pkg::ALSP_WT_DONE: next_state = alsp_pkg::ALSP_WT_IDLE;
      default: next_state = alsp_pkg::ALSP_WT_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state <= alsp_pkg::ALSP_WT_IDLE;
      step_cnt <= 18'h0;
      steps_left <= 12'h0;
    end else begin
      state <= next_state;
      step_cnt <= next_step_cnt;
      steps_left <= next_steps_left;
    end
  end

  assign wait_busy = (state == alsp_pkg::ALSP_WT_RUN);
  assign wait_done = (state == alsp_pkg::ALSP_WT_DONE);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_wait_span_load: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    state == alsp_pkg::ALSP_WT_IDLE && wait_start |=>
    steps_left == $past(span) && wait_busy)
    else $error("wait span not loaded");
  a_wait_short_len: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    state == alsp_pkg::ALSP_WT_IDLE && wait_start
    && wait_cycle_count == 8'hFF && !long_wait_multiplier && STEP_CYC < 900
    |-> ##[1:900] wait_done)
    else $error("single wait step too long");
  c_wait_done: cover property (@(posedge sys_clk) wait_done);

endmodule
`default_nettype wire

// ===== alsp_persist.sv
/*
  Light interrupt persistence filter with its persistence and configuration
  registers, a status read and the wait timer.
  Assumes the serial interface delivers byte writes and reads as one-cycle
  strobes, and that threshold, gain and wait values come from neighbour regs.
*/
// Overview of operation
// - Interrupt decision uses channel 0 result only, never channel 1.
// - Persistence field is bits 3:0 of persistence register.
// - Code 0000 raises interrupt after every conversion.
// - Code 0001 raises on one out-of-window result.
// - Codes 0010, 0011 need two, three consecutive out-of-window results.
// - Codes 0100 to 1111 need 5 to 60 results, step five.
// - Fire every conversion or after selected out-of-window duration.
// - Reduced gain bit scales 1x and 8x gains by 0.16.
// - Long wait bit multiplies wait cycles by twelve.
// - Out of window means below low or above high threshold.
// - Wait steps of 2.73 ms, count as two's complement.
// - Raised interrupt sets pending flag, status bit 4.
`timescale 1ns/1ns
`default_nettype none
module alsp_persist #(
  parameter int WAIT_STEP_CYC = alsp_pkg::WAIT_STEP_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  output logic [7:0] reg_rdata,
  input wire logic conv_done,
  input wire logic [15:0] channel0_value,
  input wire logic [15:0] low_threshold,
  input wire logic [15:0] high_threshold,
  input wire logic [1:0] analog_gain_select,
  input wire logic [7:0] wait_cycle_count,
  input wire logic wait_start,
  input wire logic irq_clear,
  output logic light_irq_pending,
  output logic light_irq_raise,
  output logic reduced_gain_active,
  output logic wait_busy,
  output logic wait_done
);

  logic [7:0] interrupt_persistence, next_interrupt_persistence;
  logic [7:0] gain_and_wait_config, next_gain_and_wait_config;
  logic [7:0] next_reg_rdata;
  logic [5:0] run_count, next_run_count;
  logic next_light_irq_pending, next_light_irq_raise;
  logic next_reduced_gain_active;
  logic [3:0] light_irq_filter_count;
  logic [5:0] target;
  logic out_window;
  logic [5:0] run_inc;
  logic timer_busy, timer_done;
  logic busy_q, done_q;

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  // field position
  assign light_irq_filter_count =
    interrupt_persistence[alsp_pkg::PERSIST_MSB:0];

  always_comb begin
    next_interrupt_persistence = interrupt_persistence;
    next_gain_and_wait_config = gain_and_wait_config;
    if (reg_wr && reg_addr == alsp_pkg::PERSIST_ADDR) begin
      next_interrupt_persistence = reg_wdata;
    end
    if (reg_wr && reg_addr == alsp_pkg::CFG_ADDR) begin
      next_gain_and_wait_config = reg_wdata;
    end
    case (reg_addr)
      alsp_pkg::PERSIST_ADDR: next_reg_rdata = interrupt_persistence;
      alsp_pkg::CFG_ADDR: next_reg_rdata = gain_and_wait_config;
      alsp_pkg::STATUS_ADDR: begin
        next_reg_rdata = 8'h00;
        next_reg_rdata[alsp_pkg::STATUS_PEND_BIT] = light_irq_pending;
      end
      default: next_reg_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      interrupt_persistence <= alsp_pkg::PERSIST_RESET;
      gain_and_wait_config <= alsp_pkg::CFG_RESET;
      reg_rdata <= 8'h00;
    end else begin
      interrupt_persistence <= next_interrupt_persistence;
      gain_and_wait_config <= next_gain_and_wait_config;
      reg_rdata <= next_reg_rdata;
    end
  end

  // ------------------------------------------------------------
  // Persistence filter
  // ------------------------------------------------------------
  // channel 0 compare only
  assign out_window = (channel0_value < low_threshold) ||
                      (channel0_value > high_threshold);

  always_comb begin
    if (light_irq_filter_count <= alsp_pkg::PERSIST_LINEAR_MAX) begin
      target = {2'h0, light_irq_filter_count};
    end else begin
      target = 6'({2'h0, light_irq_filter_count -
        alsp_pkg::PERSIST_LINEAR_MAX} * 6'h05);
    end
  end

  assign run_inc = (run_count == 6'h3F) ? run_count : run_count + 6'h1;

  always_comb begin
    next_run_count = run_count;
    next_light_irq_raise = 1'b0;
    if (conv_done) begin
      if (light_irq_filter_count == alsp_pkg::PERSIST_EVERY) begin
        next_light_irq_raise = 1'b1;
        next_run_count = 6'h0;
      end else if (out_window) begin
        next_run_count = run_inc;
        next_light_irq_raise = (run_inc >= target);
      end else begin
        next_run_count = 6'h0;
      end
    end
    next_light_irq_pending = next_light_irq_raise ||
                             (light_irq_pending && !irq_clear);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      run_count <= 6'h0;
      light_irq_raise <= 1'b0;
      light_irq_pending <= 1'b0;
    end else begin
      run_count <= next_run_count;
      light_irq_raise <= next_light_irq_raise;
      light_irq_pending <= next_light_irq_pending;
    end
  end

  // ------------------------------------------------------------
  // Gain scaling and wait timer
  // ------------------------------------------------------------
  // scaled only at 1x and 8x
  always_comb begin
    next_reduced_gain_active = gain_and_wait_config[alsp_pkg::CFG_RG_BIT] &&
                               (analog_gain_select <= alsp_pkg::GAIN_8X);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      reduced_gain_active <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      reduced_gain_active <= next_reduced_gain_active;
      busy_q <= timer_busy;
      done_q <= timer_done;
    end
  end

  assign wait_busy = busy_q;
  assign wait_done = done_q;

  alsp_wait_timer #(
    .STEP_CYC(WAIT_STEP_CYC)
  ) u_wait (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .wait_start(wait_start),
    .wait_cycle_count(wait_cycle_count),
    .long_wait_multiplier(gain_and_wait_config[alsp_pkg::CFG_LW_BIT]),
    .wait_busy(timer_busy),
    .wait_done(timer_done)
  );

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_every_conv_irq: assert property (
    conv_done && light_irq_filter_count == 4'h0 |=> light_irq_raise)
    else $error("code zero did not raise");
  a_single_out_irq: assert property (
    conv_done && light_irq_filter_count == 4'h1 && out_window
    |=> light_irq_raise && light_irq_pending)
    else $error("single out of window result missed");
  a_raise_run_len: assert property (
    light_irq_raise && $past(light_irq_filter_count) != 4'h0
    |-> run_count >= $past(target) && run_count != 6'h0)
    else $error("raise before run length reached");
  a_two_consec_out: assert property (
    light_irq_filter_count == 4'h2 && !reg_wr && conv_done && !out_window
    ##1 conv_done && out_window |=> !light_irq_raise)
    else $error("code two fired after one result");
  a_inwin_clear_cnt: assert property (
    conv_done && !out_window &&
    light_irq_filter_count != alsp_pkg::PERSIST_EVERY
    |=> run_count == 6'h0 && !light_irq_raise)
    else $error("in window result did not clear run");
  a_raise_sets_flag: assert property (
    light_irq_raise |-> light_irq_pending)
    else $error("pending flag not set");
  a_pend_until_clr: assert property (
    light_irq_pending && !irq_clear |=> light_irq_pending)
    else $error("pending flag lost without clear");
  a_interrupt_persistence_readback: assert property (
    reg_wr && reg_addr == alsp_pkg::PERSIST_ADDR ##1
    !reg_wr && reg_addr == alsp_pkg::PERSIST_ADDR
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("persistence readback wrong");
  a_gain_scale_sel: assert property (
    reduced_gain_active |-> $past(analog_gain_select) <= alsp_pkg::GAIN_8X)
    else $error("reduced gain above 8x");
  a_no_raise_idle: assert property (
    !conv_done |=> !light_irq_raise)
    else $error("raise without conversion");

  c_every_conv: cover property (
    conv_done && light_irq_filter_count == 4'h0 ##1 light_irq_raise);
  c_sixty_run: cover property (
    light_irq_raise && light_irq_filter_count == 4'hF);
  c_set_and_clear: cover property (
    next_light_irq_raise && irq_clear && light_irq_pending);

endmodule
`default_nettype wire

// ===== alsp_host.sv
/*
  Host model: byte writes and reads on the register strobe port.
  Assumes the bench calls its tasks from one process, clock from the bench.
*/
`timescale 1ns/1ns
`default_nettype none
module alsp_host (
  input wire logic sys_clk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
  end

  function automatic logic [7:0] clean(input logic [7:0] a,
                                       input logic [7:0] d);
    if (a == alsp_pkg::PERSIST_ADDR)
      return d & 8'h0F;
    if (a == alsp_pkg::CFG_ADDR)
      return d & 8'h06;
    return d;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = clean(a, d);
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_wdata = ~reg_wdata;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ===== als_interrupt_persistence_config_test.sv
/*
  Self-checking bench for the persistence and configuration block.
  Assumes the host model drives the register port.
*/
`timescale 1ns/1ns
`default_nettype none
module als_interrupt_persistence_config_test;
  localparam int STEP = 5;
  localparam logic [15:0] MID = 16'h0096;
  localparam logic [15:0] LO = 16'h0032;
  localparam logic [15:0] HI = 16'h00FA;
  logic sys_clk, rst_b, reg_wr, conv_done, wait_start, irq_clear;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, wcount, rv;
  logic [15:0] ch0, low_th, high_th;
  logic [1:0] gain;
  logic pend, raise, rga, wbusy, wdone;
  int mismatches, tests_run, c, n, k;

  alsp_persist #(.WAIT_STEP_CYC(STEP)) uut (.sys_clk(sys_clk),
    .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata(reg_rdata), .conv_done(conv_done),
    .channel0_value(ch0), .low_threshold(low_th),
    .high_threshold(high_th), .analog_gain_select(gain),
    .wait_cycle_count(wcount), .wait_start(wait_start),
    .irq_clear(irq_clear), .light_irq_pending(pend),
    .light_irq_raise(raise), .reduced_gain_active(rga),
    .wait_busy(wbusy), .wait_done(wdone));
  alsp_host host (.sys_clk(sys_clk), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got,
               exp);
    end
  endtask

  task automatic regchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, rv);
    chk({8'h00, rv}, {8'h00, exp}, "register");
  endtask

  task automatic conv(input logic [15:0] v, input logic exp);
    @(negedge sys_clk);
    conv_done = 1'b1;
    ch0 = v;
    @(negedge sys_clk);
    conv_done = 1'b0;
    ch0 = ~v;
    chk({15'h0000, raise}, {15'h0000, exp}, "raise");
  endtask

  task automatic wait_run(input logic [7:0] wc, input int steps,
                          input logic lw);
    int cnt;
    host.wr(alsp_pkg::CFG_ADDR, {6'h00, lw, 1'b0});
    wcount = wc;
    @(negedge sys_clk);
    wait_start = 1'b1;
    @(negedge sys_clk);
    wait_start = 1'b0;
    cnt = 1;
    while (wdone !== 1'b1 && cnt < 2000) begin
      @(negedge sys_clk);
      cnt++;
    end
    chk({15'h0000, cnt >= steps * STEP && cnt <= steps * STEP + 5},
        16'h0001, "wait length");
    if (cnt >= 2000)
      summarize();
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    conv_done = 1'b0;
    wait_start = 1'b0;
    irq_clear = 1'b0;
    ch0 = MID;
    low_th = 16'h0064;
    high_th = 16'h00C8;
    gain = 2'h0;
    wcount = 8'hFF;
    mismatches = 0;
    tests_run = 0;
    repeat (4) @(negedge sys_clk);
    rst_b = 1'b1;
    regchk(alsp_pkg::PERSIST_ADDR, 8'h00);
    regchk(alsp_pkg::CFG_ADDR, 8'h00);
    regchk(alsp_pkg::STATUS_ADDR, 8'h00);
    regchk(8'h20, 8'h00);
    host.wr(alsp_pkg::PERSIST_ADDR, 8'hF5);
    regchk(alsp_pkg::PERSIST_ADDR, 8'h05);
    host.wr(alsp_pkg::CFG_ADDR, 8'hFF);
    regchk(alsp_pkg::CFG_ADDR, 8'h06);
    for (k = 0; k < 4; k++) begin
      // reduced gain cleared before high gains
      if (k == 2) begin
        host.wr(alsp_pkg::CFG_ADDR, 8'h02);
      end
      gain = k[1:0];
      repeat (2) @(negedge sys_clk);
      chk({15'h0000, rga}, {15'h0000, k < 2}, "reduced gain");
    end
    gain = 2'h1;
    host.wr(alsp_pkg::CFG_ADDR, 8'h06);
    repeat (2) @(negedge sys_clk);
    chk({15'h0000, rga}, 16'h0001, "reduced gain on");
    host.wr(alsp_pkg::CFG_ADDR, 8'h02);
    repeat (2) @(negedge sys_clk);
    chk({15'h0000, rga}, 16'h0000, "reduced gain off");
    host.wr(alsp_pkg::PERSIST_ADDR, 8'h00);
    conv(MID, 1'b1);
    chk({15'h0000, pend}, 16'h0001, "pending");
    regchk(alsp_pkg::STATUS_ADDR, 8'h10);
    @(negedge sys_clk);
    irq_clear = 1'b1;
    @(negedge sys_clk);
    irq_clear = 1'b0;
    regchk(alsp_pkg::STATUS_ADDR, 8'h00);
    conv(MID, 1'b1);
    // Raise and clear in one cycle
    @(negedge sys_clk);
    conv_done = 1'b1;
    irq_clear = 1'b1;
    @(negedge sys_clk);
    conv_done = 1'b0;
    irq_clear = 1'b0;
    chk({15'h0000, pend}, 16'h0001, "set over clear");
    regchk(alsp_pkg::STATUS_ADDR, 8'h10);
    for (c = 1; c < 16; c++) begin
      n = (c < 4) ? c : (c - 3) * 5;
      host.wr(alsp_pkg::PERSIST_ADDR, c[7:0]);
      conv(MID, 1'b0);
      for (k = 1; k < n; k++) conv(k[0] ? LO : HI, 1'b0);
      conv(MID, 1'b0);
      for (k = 1; k < n; k++) conv(HI, 1'b0);
      conv(LO, 1'b1);
      conv(HI, 1'b1);
    end
    host.wr(alsp_pkg::PERSIST_ADDR, 8'h01);
    conv(16'h0064, 1'b0);
    conv(16'h00C8, 1'b0);
    conv(16'h0063, 1'b1);
    conv(16'h00C9, 1'b1);
    low_th = LO;
    conv(LO, 1'b0);
    high_th = HI;
    conv(16'h00C9, 1'b0);
    conv(HI, 1'b0);
    low_th = 16'h0064;
    high_th = 16'h00C8;
    // Back to back conversions, code two
    host.wr(alsp_pkg::PERSIST_ADDR, 8'h02);
    @(negedge sys_clk);
    conv_done = 1'b1;
    ch0 = MID;
    @(negedge sys_clk);
    ch0 = HI;
    @(negedge sys_clk);
    chk({15'h0000, raise}, 16'h0000, "raise after one");
    @(negedge sys_clk);
    conv_done = 1'b0;
    chk({15'h0000, raise}, 16'h0001, "raise after two");
    wait_run(8'hFF, 1, 1'b0);
    wait_run(8'hF6, 10, 1'b0);
    wait_run(8'hFE, 24, 1'b1);
    summarize();
  end
endmodule
`default_nettype wire
